// File: logic/dus_consts.svh
// offsets, field positions, reset values and command codes of the status block
`ifndef DUS_CONSTS_SVH
`define DUS_CONSTS_SVH

`define DUS_OFF_CHAN_A_STATUS   8'h00
`define DUS_OFF_CHAN_B_STATUS   8'h04
`define DUS_OFF_OUT_PIN_FUNC    8'h08
`define DUS_OFF_OUT_PIN_VALUE   8'h0c
`define DUS_OFF_AUX_CONTROL     8'h10
`define DUS_OFF_INPUT_CHANGE    8'h14
`define DUS_OFF_IRQ_STATUS      8'h18
`define DUS_OFF_IRQ_MASK        8'h1c

`define DUS_RST_OUT_PIN_FUNC    8'h00
`define DUS_RST_OUT_PIN_VALUE   8'h00
`define DUS_RST_AUX_CONTROL     8'h00
`define DUS_RST_IRQ_STATUS      8'h00
`define DUS_RST_IRQ_MASK        8'h00

`define DUS_CMD_RESET_ERR       3'h4
`define DUS_FIFO_DEPTH          3

`define DUS_AUX_BAUD_SET        7
`define DUS_AUX_CT_MSB          6
`define DUS_AUX_CT_LSB          4
`define DUS_FSEL_PIN3_MSB       3
`define DUS_FSEL_PIN3_LSB       2
`define DUS_FSEL_PIN2_MSB       1
`define DUS_FSEL_PIN2_LSB       0
`define DUS_FSEL_PIN4           4
`define DUS_FSEL_PIN5           5
`define DUS_FSEL_PIN6           6

`define DUS_ISR_TX_A            0
`define DUS_ISR_RX_A            1
`define DUS_ISR_BRK_A           2
`define DUS_ISR_CT_READY        3
`define DUS_ISR_TX_B            4
`define DUS_ISR_RX_B            5
`define DUS_ISR_BRK_B           6
`define DUS_ISR_INPUT_CHG       7

`endif

// File: logic/dus_pkg.sv
// types shared by the status and interrupt block
package dus_pkg;

  typedef struct packed {
    logic brk;
    logic frame;
    logic parity;
  } dus_err_type;

  typedef struct packed {
    logic        overrun;
    logic        tx_empty;
    logic        tx_ready;
    logic        rx_full;
    logic        rx_ready;
    logic        break_change;
    logic        rx_int_sel;
    logic        rx_flow;
    logic        tx_flow;
    logic        rts;
    logic        block_mode;
    logic        rx_push;
    logic        rx_pop;
    dus_err_type rx_flags;
    logic        tx_clk_16x;
    logic        tx_clk_1x;
    logic        rx_clk_1x;
  } dus_chan_type;

  typedef struct packed {
    logic       valid;
    logic [2:0] misc;
  } dus_cmd_type;

  typedef enum logic [2:0] {
    DUS_SRC_PIN2,
    DUS_SRC_TX_A,
    DUS_SRC_TX_B,
    DUS_SRC_XTAL_16,
    DUS_SRC_PIN2_16,
    DUS_SRC_XTAL
  } dus_ct_src_type;

endpackage

// File: logic/dus_err_track.sv
// per-character error flags kept beside the receive fifo
`timescale 1ns/1ps
`default_nettype none
`include "dus_consts.svh"
module dus_err_track #(
  parameter int DEPTH = `DUS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // fifo activity
  input  wire logic                 push,
  input  wire dus_pkg::dus_err_type push_flags,
  input  wire logic                 pop,
  input  wire logic                 clr,
  input  wire logic                 block_mode,
  // flags shown in the status byte
  output dus_pkg::dus_err_type      err_flags
);
  import dus_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  dus_err_type      mem_r [DEPTH];
  logic [CW-1:0]    count_r;
  dus_err_type      acc_r;
  logic             do_pop;
  logic             do_push;
  logic [CW-1:0]    wr_idx;

  assign do_pop  = pop && (count_r != '0);
  assign do_push = push && ((count_r != CW'(DEPTH)) || do_pop);
  assign wr_idx  = do_pop ? count_r - 1'b1 : count_r;

  // flags travel with their character; read-out drops the top entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (do_pop && i < DEPTH - 1) begin
          mem_r[i] <= clr ? '0 : mem_r[i+1];
        end else if (clr) begin
          mem_r[i] <= '0;
        end
        if (do_push && wr_idx == CW'(i)) begin
          mem_r[i] <= push_flags;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (do_push && !do_pop) begin
      count_r <= count_r + 1'b1;
    end else if (do_pop && !do_push) begin
      count_r <= count_r - 1'b1;
    end
  end

  // block mode accumulates every top entry until reset-error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= '0;
    end else if (clr) begin
      acc_r <= '0;
    end else if (count_r != '0) begin
      acc_r <= acc_r | mem_r[0];
    end
  end

  assign err_flags = (count_r == '0) ? (block_mode ? acc_r : '0) :
                     (block_mode ? (acc_r | mem_r[0]) : mem_r[0]);

  a_pop_discards: assert property (@(posedge pclk) disable iff (!presetn)
    (!block_mode && count_r == CW'(1) && do_pop && !do_push) |=> err_flags == '0)
    else $error("character mode flags not dropped on read");

endmodule
`default_nettype wire

// File: logic/dus_status_regs.sv
// status, output port, auxiliary control and interrupt registers on apb
`timescale 1ns/1ps
`default_nettype none
`include "dus_consts.svh"
// Summary of operation
// - error flags stored with each received character
// - status read: fifo flags plus five live bits
// - reset-error command clears the fifo flags
// - character mode drops flags on character read
// - pins zero and one carry rts when enabled
// - mode field decodes counter or timer source
// - pin two clock blocks channel b receiver
// - enable bits gate pin changes to interrupt
// - change register upper bits latch pin changes
// - change register lower bits show pin levels
// - interrupt status layout, masked onto request
// - miscellaneous code four is reset-error
// - block mode ors flags since reset-error
module dus_status_regs (
  // apb slave
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // serial channels and commands
  input  wire dus_pkg::dus_chan_type chan_a,
  input  wire dus_pkg::dus_chan_type chan_b,
  input  wire dus_pkg::dus_cmd_type  cmd_a,
  input  wire dus_pkg::dus_cmd_type  cmd_b,
  // counter/timer
  input  wire logic                  ct_out,
  input  wire logic                  ct_ready,
  output dus_pkg::dus_ct_src_type    ct_source,
  output logic                       ct_timer_mode,
  output logic                       baud_set_2,
  output logic                       rxb_pin2_clk_en,
  // pins
  input  wire logic [3:0]            in_pin,
  output logic [7:0]                 out_pin,
  // interrupt
  output logic                       irq
);
  import dus_pkg::*;

  logic [7:0]   fsel_r;
  logic [7:0]   pval_r;
  logic [7:0]   aux_r;
  logic [7:0]   isr_r;
  logic [7:0]   isr_nxt;
  logic [7:0]   mask_r;
  logic [3:0]   delta_r;
  logic [3:0]   level_r;
  logic [3:0]   pin_s1_r;
  logic [3:0]   pin_s2_r;
  logic [3:0]   pin_chg;
  logic [7:0]   out_pin_nxt;
  logic [4:0]   prev_lvl_r;
  logic [4:0]   cur_lvl;
  logic [4:0]   rise;
  logic         setup;
  logic         wr_en;
  logic         rd_done;
  logic         mapped;
  logic [31:0]  rdata_nxt;
  logic         rst_err_a;
  logic         rst_err_b;
  dus_err_type  err_a;
  dus_err_type  err_b;
  logic [7:0]   status_a;
  logic [7:0]   status_b;
  logic         rx_int_a;
  logic         rx_int_b;
  logic [7:0]   isr_event;
  logic [3:0]   level_hold_r;

  // decodes the counter/timer mode and source field
  function automatic dus_ct_src_type ct_decode(input logic [2:0] f);
    case (f)
      3'h0:    ct_decode = DUS_SRC_PIN2;
      3'h1:    ct_decode = DUS_SRC_TX_A;
      3'h2:    ct_decode = DUS_SRC_TX_B;
      3'h3:    ct_decode = DUS_SRC_XTAL_16;
      3'h4:    ct_decode = DUS_SRC_PIN2;
      3'h5:    ct_decode = DUS_SRC_PIN2_16;
      3'h6:    ct_decode = DUS_SRC_XTAL;
      default: ct_decode = DUS_SRC_XTAL_16;
    endcase
  endfunction

  // true when a command is reset-error-status
  function automatic logic is_rst_err(input dus_cmd_type c);
    is_rst_err = c.valid && (c.misc == `DUS_CMD_RESET_ERR);
  endfunction

  // apb handshake
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign rd_done = psel && penable && !pwrite;
  assign pready  = 1'b1;

  always_comb begin
    mapped = 1'b1;
    if (paddr == `DUS_OFF_CHAN_A_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_CHAN_B_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_OUT_PIN_FUNC) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_OUT_PIN_VALUE) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_AUX_CONTROL) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_INPUT_CHANGE) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_IRQ_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == `DUS_OFF_IRQ_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr = psel && penable && !mapped;

  // error flag tracking per channel
  assign rst_err_a = is_rst_err(cmd_a);
  assign rst_err_b = is_rst_err(cmd_b);

  dus_err_track #(.DEPTH(`DUS_FIFO_DEPTH)) u_err_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .push       (chan_a.rx_push),
    .push_flags (chan_a.rx_flags),
    .pop        (chan_a.rx_pop),
    .clr        (rst_err_a),
    .block_mode (chan_a.block_mode),
    .err_flags  (err_a)
  );

  dus_err_track #(.DEPTH(`DUS_FIFO_DEPTH)) u_err_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .push       (chan_b.rx_push),
    .push_flags (chan_b.rx_flags),
    .pop        (chan_b.rx_pop),
    .clr        (rst_err_b),
    .block_mode (chan_b.block_mode),
    .err_flags  (err_b)
  );

  assign status_a = {err_a, chan_a.overrun, chan_a.tx_empty, chan_a.tx_ready,
                     chan_a.rx_full, chan_a.rx_ready};
  assign status_b = {err_b, chan_b.overrun, chan_b.tx_empty, chan_b.tx_ready,
                     chan_b.rx_full, chan_b.rx_ready};

  // read data captured in the setup cycle
  always_comb begin
    rdata_nxt = 32'h0;
    if (paddr == `DUS_OFF_CHAN_A_STATUS) begin
      rdata_nxt[7:0] = status_a;
    end else if (paddr == `DUS_OFF_CHAN_B_STATUS) begin
      rdata_nxt[7:0] = status_b;
    end else if (paddr == `DUS_OFF_OUT_PIN_FUNC) begin
      rdata_nxt[7:0] = fsel_r;
    end else if (paddr == `DUS_OFF_OUT_PIN_VALUE) begin
      rdata_nxt[7:0] = pval_r;
    end else if (paddr == `DUS_OFF_AUX_CONTROL) begin
      rdata_nxt[7:0] = aux_r;
    end else if (paddr == `DUS_OFF_INPUT_CHANGE) begin
      rdata_nxt[7:0] = {delta_r, level_r};
    end else if (paddr == `DUS_OFF_IRQ_STATUS) begin
      rdata_nxt[7:0] = isr_r;
    end else if (paddr == `DUS_OFF_IRQ_MASK) begin
      rdata_nxt[7:0] = mask_r;
    end else begin
      rdata_nxt = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsel_r <= `DUS_RST_OUT_PIN_FUNC;
      pval_r <= `DUS_RST_OUT_PIN_VALUE;
      aux_r  <= `DUS_RST_AUX_CONTROL;
      mask_r <= `DUS_RST_IRQ_MASK;
    end else if (wr_en) begin
      if (paddr == `DUS_OFF_OUT_PIN_FUNC) begin
        fsel_r <= pwdata[7:0];
      end else if (paddr == `DUS_OFF_OUT_PIN_VALUE) begin
        pval_r <= pwdata[7:0];
      end else if (paddr == `DUS_OFF_AUX_CONTROL) begin
        aux_r <= pwdata[7:0];
      end else if (paddr == `DUS_OFF_IRQ_MASK) begin
        mask_r <= pwdata[7:0];
      end
    end
  end

  // counter/timer and baud set outputs
  assign ct_source     = ct_decode(aux_r[`DUS_AUX_CT_MSB:`DUS_AUX_CT_LSB]);
  assign ct_timer_mode = aux_r[`DUS_AUX_CT_MSB];
  assign baud_set_2    = aux_r[`DUS_AUX_BAUD_SET];
  assign rxb_pin2_clk_en = (ct_source != DUS_SRC_PIN2) && (ct_source != DUS_SRC_PIN2_16);

  // input pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r     <= 4'h0;
      pin_s2_r     <= 4'h0;
      level_hold_r <= 4'h0;
    end else begin
      pin_s1_r     <= in_pin;
      pin_s2_r     <= pin_s1_r;
      level_hold_r <= pin_s2_r;
    end
  end

  assign pin_chg = pin_s2_r ^ level_hold_r;

  // change flags cleared by reading, a new change wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      delta_r <= 4'h0;
      level_r <= 4'h0;
    end else begin
      level_r <= pin_s2_r;
      if (rd_done && paddr == `DUS_OFF_INPUT_CHANGE) begin
        delta_r <= pin_chg;
      end else begin
        delta_r <= delta_r | pin_chg;
      end
    end
  end

  // interrupt events
  assign rx_int_a = chan_a.rx_int_sel ? chan_a.rx_full : chan_a.rx_ready;
  assign rx_int_b = chan_b.rx_int_sel ? chan_b.rx_full : chan_b.rx_ready;
  assign cur_lvl  = {rx_int_b, chan_b.tx_ready, rx_int_a, chan_a.tx_ready, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_lvl_r <= 5'h00;
    end else begin
      prev_lvl_r <= cur_lvl;
    end
  end

  assign rise = cur_lvl & ~prev_lvl_r;

  always_comb begin
    isr_event = 8'h00;
    isr_event[`DUS_ISR_INPUT_CHG] = |(pin_chg & aux_r[3:0]);
    isr_event[`DUS_ISR_BRK_B]     = chan_b.break_change;
    isr_event[`DUS_ISR_RX_B]      = rise[4];
    isr_event[`DUS_ISR_TX_B]      = rise[3];
    isr_event[`DUS_ISR_CT_READY]  = ct_ready;
    isr_event[`DUS_ISR_BRK_A]     = chan_a.break_change;
    isr_event[`DUS_ISR_RX_A]      = rise[2];
    isr_event[`DUS_ISR_TX_A]      = rise[1];
  end

  // sticky status, write one clears, set wins
  always_comb begin
    isr_nxt = isr_r;
    if (wr_en && paddr == `DUS_OFF_IRQ_STATUS) begin
      isr_nxt = isr_r & ~pwdata[7:0];
    end
    isr_nxt = isr_nxt | isr_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      isr_r <= `DUS_RST_IRQ_STATUS;
    end else begin
      isr_r <= isr_nxt;
    end
  end

  assign irq = |(isr_r & mask_r);

  // output port pin selection
  always_comb begin
    out_pin_nxt    = pval_r;
    out_pin_nxt[0] = (chan_a.rx_flow || chan_a.tx_flow) ? chan_a.rts : pval_r[0];
    out_pin_nxt[1] = (chan_b.rx_flow || chan_b.tx_flow) ? chan_b.rts : pval_r[1];
    case (fsel_r[`DUS_FSEL_PIN2_MSB:`DUS_FSEL_PIN2_LSB])
      2'h0:    out_pin_nxt[2] = pval_r[2];
      2'h1:    out_pin_nxt[2] = chan_a.tx_clk_16x;
      2'h2:    out_pin_nxt[2] = chan_a.tx_clk_1x;
      default: out_pin_nxt[2] = chan_a.rx_clk_1x;
    endcase
    case (fsel_r[`DUS_FSEL_PIN3_MSB:`DUS_FSEL_PIN3_LSB])
      2'h0:    out_pin_nxt[3] = pval_r[3];
      2'h1:    out_pin_nxt[3] = ct_out;
      2'h2:    out_pin_nxt[3] = chan_b.tx_clk_1x;
      default: out_pin_nxt[3] = chan_b.rx_clk_1x;
    endcase
    out_pin_nxt[4] = fsel_r[`DUS_FSEL_PIN4] ? rx_int_a : pval_r[4];
    out_pin_nxt[5] = fsel_r[`DUS_FSEL_PIN5] ? rx_int_b : pval_r[5];
    out_pin_nxt[6] = fsel_r[`DUS_FSEL_PIN6] ? chan_a.tx_ready : pval_r[6];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pin <= `DUS_RST_OUT_PIN_VALUE;
    end else begin
      out_pin <= out_pin_nxt;
    end
  end

  // checks
  sequence s_read_a;
    setup && !pwrite && paddr == `DUS_OFF_CHAN_A_STATUS;
  endsequence

  sequence s_w1c_with_event(int b);
    wr_en && paddr == `DUS_OFF_IRQ_STATUS && pwdata[b] && isr_event[b];
  endsequence

  a_irq_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (isr_r & mask_r) == 8'h00 |-> !irq)
    else $error("interrupt raised with all pending bits masked");

  a_status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_read_a |=> prdata[7:0] == $past(status_a) && prdata[31:8] == 24'h0)
    else $error("channel a status read data wrong");

  a_rst_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_err_a && !chan_a.rx_push) ##1 !chan_a.rx_push |-> err_a == 3'h0)
    else $error("reset-error did not clear channel a flags");

  a_pin_delta_set: assert property (@(posedge pclk) disable iff (!presetn)
    pin_s2_r[0] != level_hold_r[0] |=> delta_r[0])
    else $error("pin change not latched");

  a_pin_level_show: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 level_r == $past(pin_s2_r))
    else $error("change register level bits lag");

  a_input_chg_en: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_chg & aux_r[3:0]) != 4'h0 |=> isr_r[`DUS_ISR_INPUT_CHG])
    else $error("enabled pin change did not raise status");

  a_w1c_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    s_w1c_with_event(`DUS_ISR_CT_READY) |=> isr_r[`DUS_ISR_CT_READY])
    else $error("event lost under clear");

  a_pin3_timer_out: assert property (@(posedge pclk) disable iff (!presetn)
    fsel_r[3:2] == 2'h1 |=> out_pin[3] == $past(ct_out))
    else $error("pin three not following timer output");

  a_rts_pin_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (chan_a.rx_flow || chan_a.tx_flow) |=> out_pin[0] == $past(chan_a.rts))
    else $error("pin zero not carrying rts");

  a_rxb_pin_block: assert property (@(posedge pclk) disable iff (!presetn)
    aux_r[5:4] == 2'h0 || aux_r[6:4] == 3'h5 |-> !rxb_pin2_clk_en)
    else $error("pin two clock still given to receiver b");

  a_ct_decode_src: assert property (@(posedge pclk) disable iff (!presetn)
    aux_r[6:4] == 3'h6 |-> ct_source == DUS_SRC_XTAL && ct_timer_mode)
    else $error("timer crystal source decoded wrong");

endmodule
`default_nettype wire

// File: testbench/dus_host_model.sv
// apb host model that drives the status block
`timescale 1ns/1ps
`default_nettype none
module dus_host_model (
  // apb master side
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  bit hung = 0;
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
  end
  // one transfer, request held until pready
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 64; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    hung = hung | (n == 64);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule
`default_nettype wire

// File: testbench/dus_status_regs_bench.sv
// self-checking bench for the status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module dus_status_regs_bench;
  import dus_pkg::*;
  logic           pclk = 0, presetn = 0;
  logic           psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]     paddr, out_pin, v;
  logic [31:0]    pwdata, prdata, r;
  logic           ct_out = 0, ct_ready = 0, ct_timer_mode, baud_set_2, rxb_en, irq;
  logic [3:0]     in_pin = 0;
  dus_chan_type   ca = '0, cb = '0;
  dus_cmd_type    ma = '0, mb = '0;
  dus_ct_src_type ct_source;
  int             mismatches = 0, checked = 0, mi = 0, acc = 0;
  int             m [8] = '{default: 0};
  int             q [$];
  dus_ct_src_type src_tab [8] = '{DUS_SRC_PIN2, DUS_SRC_TX_A, DUS_SRC_TX_B,
    DUS_SRC_XTAL_16, DUS_SRC_PIN2, DUS_SRC_PIN2_16, DUS_SRC_XTAL, DUS_SRC_XTAL_16};

  initial forever #2 pclk = ~pclk;

  dus_status_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_a(ca), .chan_b(cb), .cmd_a(ma), .cmd_b(mb), .ct_out(ct_out),
    .ct_ready(ct_ready), .ct_source(ct_source), .ct_timer_mode(ct_timer_mode),
    .baud_set_2(baud_set_2), .rxb_pin2_clk_en(rxb_en), .in_pin(in_pin),
    .out_pin(out_pin), .irq(irq));
  dus_host_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic end_of_test();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("FAIL %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic io(input bit w, input int i, input logic [7:0] d);
    host.xfer(w, 8'(i * 4), {24'h0, d}, r, e);
    if (host.hung) begin
      mismatches++;
      end_of_test();
    end
    if (w && i inside {2, 3, 4, 7}) m[i] = d;
    if (w && i == 6) mi &= ~d;
  endtask
  task automatic rd(input int i, input logic [7:0] x);
    io(0, i, 8'h0);
    chk({e, r}, {1'b0, 24'h0, x});
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic push(input logic [2:0] f);
    @(posedge pclk);
    ca.rx_push <= 1;
    ca.rx_flags <= f;
    @(posedge pclk);
    ca.rx_push <= 0;
    if (q.size() < 3) q.push_back(f);
  endtask
  task automatic pop();
    @(posedge pclk);
    ca.rx_pop <= 1;
    @(posedge pclk);
    ca.rx_pop <= 0;
    if (q.size()) acc |= q.pop_front();
  endtask
  task automatic cmd(input logic [2:0] c);
    @(posedge pclk);
    ma <= '{1'b1, c};
    @(posedge pclk);
    ma <= '0;
    if (c == 3'h4) begin
      acc = 0;
      foreach (q[k]) q[k] = 0;
    end
  endtask
  task automatic event_on(input int b);
    @(posedge pclk);
    case (b)
      0: ca.tx_ready <= 1;
      1: ca.rx_ready <= 1;
      2: ca.break_change <= 1;
      3: ct_ready <= 1;
      4: cb.tx_ready <= 1;
      5: cb.rx_ready <= 1;
      default: cb.break_change <= 1;
    endcase
    @(posedge pclk);
    {ca.break_change, cb.break_change, ct_ready} <= 3'b0;
    mi |= 1 << b;
  endtask
  function automatic logic [7:0] stat_a();
    int t = q.size() ? q[0] : 0;
    return {3'(ca.block_mode ? (acc | t) : t), ca.overrun, ca.tx_empty, ca.tx_ready,
            ca.rx_full, ca.rx_ready};
  endfunction
  function automatic logic [7:0] pins(input logic [7:0] s);
    logic [7:0] o = 8'(m[3]);
    logic [3:0] c2 = {ca.rx_clk_1x, ca.tx_clk_1x, ca.tx_clk_16x, o[2]};
    logic [3:0] c3 = {cb.rx_clk_1x, cb.tx_clk_1x, ct_out, o[3]};
    return {o[7], s[6] ? ca.tx_ready : o[6],
            s[5] ? (cb.rx_int_sel ? cb.rx_full : cb.rx_ready) : o[5],
            s[4] ? (ca.rx_int_sel ? ca.rx_full : ca.rx_ready) : o[4], c3[s[3:2]], c2[s[1:0]],
            cb.rx_flow | cb.tx_flow ? cb.rts : o[1], ca.rx_flow | ca.tx_flow ? ca.rts : o[0]};
  endfunction

  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    void'($urandom(31));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    // reset values and unmapped access
    for (int i = 0; i < 8; i++) rd(i, 8'h0);
    io(0, 8, 8'h0);
    chk({e, r}, {1'b1, 32'h0});
    // counter/timer mode decode, channels idle while changed
    for (int k = 0; k < 8; k++) begin
      io(1, 4, {1'($urandom), 3'(k), 4'h0});
      rd(4, 8'(m[4]));
      chk(33'({ct_timer_mode, baud_set_2, rxb_en, ct_source}),
          33'({k[2], m[4][7], !(k inside {0, 4, 5}), src_tab[k]}));
    end
    // pin routing, timer armed before pin three takes it
    io(1, 4, 8'h40);
    io(1, 3, 8'($urandom));
    for (int k = 0; k < 16; k++) begin
      v = {1'b0, 3'($urandom), 4'(k)};
      io(1, 2, v);
      {ca.tx_ready, ca.rx_ready, ca.rx_full, ca.rx_int_sel, ca.rx_flow, ca.rts,
       ca.tx_clk_16x, ca.tx_clk_1x, ca.rx_clk_1x} <= 9'($urandom);
      {cb.rx_ready, cb.rx_full, cb.rx_int_sel, cb.tx_flow, cb.rts, cb.tx_clk_1x,
       cb.rx_clk_1x, ct_out} <= 8'($urandom);
      ticks(2);
      chk(33'(out_pin), 33'(pins(v)));
    end
    @(posedge pclk);
    ca <= '0;
    cb <= '0;
    io(1, 6, 8'hff);
    // receive flags in character mode, full fifo refuses a push
    {ca.overrun, ca.tx_empty, ca.tx_ready, ca.rx_full, ca.rx_ready} <= {4'($urandom), 1'b1};
    repeat (4) push(3'($urandom));
    for (int k = 0; k < 4; k++) begin
      rd(0, stat_a());
      pop();
    end
    push(3'h7);
    cmd(3'h5);
    rd(0, stat_a());
    cmd(3'h4);
    rd(0, stat_a());
    pop();
    // block mode accumulation
    ca.block_mode <= 1;
    cmd(3'h4);
    repeat (2) push(3'($urandom));
    for (int k = 0; k < 3; k++) begin
      rd(0, stat_a());
      pop();
    end
    cmd(3'h4);
    rd(0, stat_a());
    ca <= '0;
    io(1, 6, 8'hff);
    // each interrupt source except input change, masked then passed, then cleared
    for (int b = 0; b < 7; b++) begin
      io(1, 7, ~8'(1 << b));
      event_on(b);
      ticks(1);
      rd(6, 8'(mi));
      chk(33'(irq), 33'h0);
      io(1, 7, 8'(1 << b));
      ticks(0);
      chk(33'(irq), 33'h1);
      @(posedge pclk);
      ca <= '0;
      cb <= '0;
      io(1, 6, 8'(1 << b));
      rd(6, 8'(mi));
    end
    // pin changes, enabled and not
    io(1, 7, 8'h80);
    for (int j = 0; j < 4; j++) begin
      io(1, 4, 8'(1 << j));
      for (int h = 1; h >= 0; h--) begin
        in_pin <= in_pin ^ 4'(1 << ((j + h) % 4));
        ticks(5);
        rd(5, {4'(1 << ((j + h) % 4)), in_pin});
        rd(6, h ? 8'h0 : 8'h80);
        chk(33'(irq), 33'(!h));
        io(1, 6, 8'h80);
      end
    end
    end_of_test();
  end
endmodule
`default_nettype wire
